// >>> design/cwt_top.sv
// cascaded 16-bit timer: pwm, pulse generator and warm-up counter
//
// Behaviour
// - pwm counts one of eight selectable sources
// - pulse mode: width match inverts, keeps counting
// - period match inverts, clears, raises interrupt
// - external pin levels need two machine cycles
// - flip-flop loads preset; reset clears it
// - output pin is inverse of flip-flop
// - pulse mode compares are unbuffered, immediate
// - stopped output holds; preset write changes it
// - warm-up compares only upper period byte
// - warm-up match raises interrupt and clears
// - warm-up spans 0100H to 10000H low ticks
// - 057H selects pulse mode, 05FH starts
// - 05H selects warm-up; bit 3 starts/stops
// - 43H low clock cascade; 33H fc/8
// - pwm: width match and overflow invert
// - pwm width double-buffered, loads at interrupt
`timescale 1ns/1ps
module cwt_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic lf_clk_pin,
   input wire logic ext_count_pin,
   output logic upper_timer_interrupt,
   output logic pwm_output_pin,
   output logic pulse_generator_pin,
   output logic timer_output_flipflop
);
   import cwt_pkg::*;

   cwt_tick_if tk();

   cwt_prescaler #(
      .PRESCALE_W(PRESCALE_BITS)
   ) u_prescaler (
      .hclk(hclk),
      .hresetn(hresetn),
      .lf_clk_pin(lf_clk_pin),
      .tk(tk.prescaler)
   );

   cwt_ext_sampler u_sampler (
      .hclk(hclk),
      .hresetn(hresetn),
      .ext_count_pin(ext_count_pin),
      .tk(tk.sampler)
   );

   logic [7:0] lower_timer_control;
   logic [7:0] upper_timer_control;
   logic [7:0] period_compare_low;
   logic [7:0] period_compare_high;
   logic [15:0] width_buf;
   logic [15:0] width_act;
   logic [1:0] system_clock_control;
   logic [15:0] cnt;
   logic ff;
   logic wr_pend;
   logic [7:0] wr_addr;
   logic [7:0] wdata;
   logic [2:0] mode;
   logic [2:0] clksel;
   logic start;
   logic run;
   logic tick;
   logic pwm_run;
   logic ctrl_wr;
   logic ctrl_wr_stopped;
   logic [15:0] inc;
   logic [15:0] period;
   logic [15:0] next_cnt;
   logic next_ff;
   logic hit;
   logic load_act;
   logic addr_phase;

   function automatic logic [31:0] read_mux(input logic [7:0] a,
      input logic [7:0] lc, input logic [7:0] uc, input logic [7:0] pl,
      input logic [7:0] ph, input logic [15:0] wb, input logic [1:0] sc,
      input logic f, input logic [15:0] c);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (a)
         OFF_LOWER_CTRL: r = {24'h00_0000, lc};
         OFF_UPPER_CTRL: r = {24'h00_0000, uc};
         OFF_PERIOD_LO: r = {24'h00_0000, pl};
         OFF_PERIOD_HI: r = {24'h00_0000, ph};
         OFF_WIDTH_LO: r = {24'h00_0000, wb[7:0]};
         OFF_WIDTH_HI: r = {24'h00_0000, wb[15:8]};
         OFF_SYS_CTRL: r = {30'h0000_0000, sc};
         OFF_STATUS: r = {15'h0000, f, c};
         default: r = 32'h0000_0000;
      endcase
      return r;
   endfunction

   // source enable from the lower clock select field
   function automatic logic pick_tick(input logic [2:0] sel,
      input logic dsel, input logic ls);
      logic t;
      t = 1'b0;
      case (sel)
         CLK_FC_DIV2048: t = (dsel || ls) ? tk.fs_div8 : tk.fc_div2048;
         CLK_FC_DIV128: t = tk.fc_div128;
         CLK_FC_DIV32: t = tk.fc_div32;
         CLK_FC_DIV8: t = tk.fc_div8;
         CLK_FS: t = tk.fs_tick;
         CLK_FC_DIV2: t = tk.fc_div2;
         CLK_FC: t = !ls;
         CLK_EXT: t = tk.ext_tick;
         default: t = 1'b0;
      endcase
      return t;
   endfunction

   // one register's write strobe in the data phase
   function automatic logic wr_hit(input logic pend, input logic [7:0] a,
      input logic [7:0] off);
      return pend && a == off;
   endfunction

   // bus: address captured, write completed in the data phase
   assign addr_phase = hsel && htrans[1] && hready;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         wr_pend <= addr_phase && hwrite;
         if (addr_phase) begin
            wr_addr <= haddr[7:0];
         end
      end
   end
   assign wdata = hwdata[7:0];

   // zero wait state, always okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // reads see the state of the address edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         hrdata <= read_mux(haddr[7:0], lower_timer_control,
            upper_timer_control, period_compare_low,
            period_compare_high, width_buf, system_clock_control,
            ff, cnt);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lower_timer_control <= RST_CTRL;
      end else if (wr_hit(wr_pend, wr_addr, OFF_LOWER_CTRL)) begin
         lower_timer_control <= wdata;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         upper_timer_control <= RST_CTRL;
      end else if (ctrl_wr) begin
         upper_timer_control <= wdata;
      end
   end

   // only the two low bits are kept; the rest of the byte drops here
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         system_clock_control <= RST_SYS;
      end else if (wr_hit(wr_pend, wr_addr, OFF_SYS_CTRL)) begin
         system_clock_control <= wdata[1:0];
      end
   end

   // period has no shadow: a write is live on the next compare
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         period_compare_low <= RST_CMP;
      end else if (wr_hit(wr_pend, wr_addr, OFF_PERIOD_LO)) begin
         period_compare_low <= wdata;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         period_compare_high <= RST_CMP;
      end else if (wr_hit(wr_pend, wr_addr, OFF_PERIOD_HI)) begin
         period_compare_high <= wdata;
      end
   end

   // width: buffer always written; active copy direct unless pwm runs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         width_buf <= {RST_CMP, RST_CMP};
         width_act <= {RST_CMP, RST_CMP};
      end else begin
         if (load_act) begin
            width_act <= width_buf;
         end
         if (wr_pend && wr_addr == OFF_WIDTH_LO) begin
            width_buf[7:0] <= wdata;
            if (!pwm_run) begin
               width_act[7:0] <= wdata;
            end
         end
         if (wr_pend && wr_addr == OFF_WIDTH_HI) begin
            width_buf[15:8] <= wdata;
            if (!pwm_run) begin
               width_act[15:8] <= wdata;
            end
         end
      end
   end

   assign tk.low_speed = system_clock_control[SYS_LOWSPEED_BIT];
   assign tk.div_select = system_clock_control[SYS_DIVSEL_BIT];
   assign mode = upper_timer_control[CTRL_MODE_LSB +: 3];
   assign clksel = lower_timer_control[CTRL_CLKSEL_LSB +: 3];
   assign start = upper_timer_control[CTRL_START_BIT];
   assign pwm_run = start && mode == MODE_PWM;
   assign run = start
      && lower_timer_control[CTRL_MODE_LSB +: 3] == LOWER_MODE_CASCADE
      && (mode == MODE_WARMUP || mode == MODE_PWM || mode == MODE_PPG);
   // always_comb so the taps read inside the function wake it up
   always_comb begin
      tick = pick_tick(clksel, tk.div_select, tk.low_speed);
   end
   assign ctrl_wr = wr_hit(wr_pend, wr_addr, OFF_UPPER_CTRL);
   // a write that stops the timer must not also move the output
   assign ctrl_wr_stopped = ctrl_wr && !start;
   assign inc = cnt + 16'h0001;
   assign period = {period_compare_high, period_compare_low};

   always_comb begin
      next_cnt = cnt;
      next_ff = ff;
      hit = 1'b0;
      load_act = 1'b0;
      if (ctrl_wr_stopped) begin
         next_ff = wdata[CTRL_PRESET_BIT];
         if (wdata[CTRL_START_BIT]) begin
            next_cnt = 16'h0000;
         end
      end else if (run && tick) begin
         case (mode)
            MODE_WARMUP: begin
               // low byte of the period is ignored
               if (inc == {period_compare_high, 8'h00}) begin
                  next_cnt = 16'h0000;
                  hit = 1'b1;
               end else begin
                  next_cnt = inc;
               end
            end
            MODE_PPG: begin
               next_cnt = inc;
               if (inc == width_act) begin
                  next_ff = !next_ff;
               end
               if (inc == period) begin
                  next_ff = !next_ff;
                  next_cnt = 16'h0000;
                  hit = 1'b1;
               end
            end
            MODE_PWM: begin
               if (cnt == COUNT_TOP) begin
                  next_ff = !ff;
                  next_cnt = 16'h0000;
                  hit = 1'b1;
                  load_act = 1'b1;
               end else begin
                  next_cnt = inc;
                  if (inc == width_act) begin
                     next_ff = !ff;
                  end
               end
            end
            default: begin
               next_cnt = cnt;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 16'h0000;
      end else begin
         cnt <= next_cnt;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ff <= 1'b0;
      end else begin
         ff <= next_ff;
      end
   end

   // pins come straight from flops, inverted copy of the flip-flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_output_flipflop <= 1'b0;
         pwm_output_pin <= 1'b1;
         pulse_generator_pin <= 1'b1;
      end else begin
         timer_output_flipflop <= next_ff;
         pwm_output_pin <= !next_ff;
         pulse_generator_pin <= !next_ff;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         upper_timer_interrupt <= 1'b0;
      end else begin
         upper_timer_interrupt <= hit;
      end
   end
endmodule

// >>> pkg/cwt_pkg.sv
// constants shared by the cascaded warm-up timer design
package cwt_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_LOWER_CTRL = 8'h00;
   localparam logic [7:0] OFF_UPPER_CTRL = 8'h04;
   localparam logic [7:0] OFF_PERIOD_LO = 8'h08;
   localparam logic [7:0] OFF_PERIOD_HI = 8'h0C;
   localparam logic [7:0] OFF_WIDTH_LO = 8'h10;
   localparam logic [7:0] OFF_WIDTH_HI = 8'h14;
   localparam logic [7:0] OFF_SYS_CTRL = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1C;
   // reset values
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_CMP = 8'h00;
   localparam logic [1:0] RST_SYS = 2'h0;
   // control field positions
   localparam int CTRL_PRESET_BIT = 7;
   localparam int CTRL_START_BIT = 3;
   localparam int CTRL_CLKSEL_LSB = 4;
   localparam int CTRL_MODE_LSB = 0;
   localparam int SYS_DIVSEL_BIT = 0;
   localparam int SYS_LOWSPEED_BIT = 1;
   localparam int STATUS_FF_BIT = 16;
   // upper control mode codes
   localparam logic [2:0] MODE_WARMUP = 3'h5;
   localparam logic [2:0] MODE_PWM = 3'h6;
   localparam logic [2:0] MODE_PPG = 3'h7;
   // lower control mode code for cascaded 16-bit operation
   localparam logic [2:0] LOWER_MODE_CASCADE = 3'h3;
   // lower control clock select codes
   localparam logic [2:0] CLK_FC_DIV2048 = 3'h0;
   localparam logic [2:0] CLK_FC_DIV128 = 3'h1;
   localparam logic [2:0] CLK_FC_DIV32 = 3'h2;
   localparam logic [2:0] CLK_FC_DIV8 = 3'h3;
   localparam logic [2:0] CLK_FS = 3'h4;
   localparam logic [2:0] CLK_FC_DIV2 = 3'h5;
   localparam logic [2:0] CLK_FC = 3'h6;
   localparam logic [2:0] CLK_EXT = 3'h7;
   // timing counts
   localparam int FC_HZ = 100_000_000;
   localparam int PRESCALE_BITS = 11;
   localparam logic [1:0] MCYC_DIV_LAST = 2'h3;
   localparam logic [2:0] FS_DIV8_LAST = 3'h7;
   localparam logic [15:0] COUNT_TOP = 16'hFFFF;
endpackage

// >>> pkg/cwt_tick_if.sv
// count enables passed from prescaler and pin sampler to the timer core
`timescale 1ns/1ps
interface cwt_tick_if;
   logic low_speed;
   logic div_select;
   logic fc_div2;
   logic fc_div8;
   logic fc_div32;
   logic fc_div128;
   logic fc_div2048;
   logic fs_tick;
   logic fs_div8;
   logic mcyc;
   logic ext_tick;
   modport prescaler(input low_speed, input div_select, output fc_div2,
      output fc_div8, output fc_div32, output fc_div128,
      output fc_div2048, output fs_tick, output fs_div8, output mcyc);
   modport sampler(input mcyc, output ext_tick);
   modport core(output low_speed, output div_select, input fc_div2,
      input fc_div8, input fc_div32, input fc_div128, input fc_div2048,
      input fs_tick, input fs_div8, input ext_tick);
endinterface

// >>> design/cwt_prescaler.sv
// divider producing the source clock enables and the machine cycle
`timescale 1ns/1ps
module cwt_prescaler #(
   parameter int PRESCALE_W = cwt_pkg::PRESCALE_BITS
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic lf_clk_pin,
   cwt_tick_if.prescaler tk
);
   import cwt_pkg::*;

   // elaboration check: the widest tap needs every divider bit
   if (PRESCALE_W < PRESCALE_BITS) begin
      $error("prescaler too narrow for the divide by 2048 tap");
   end

   logic [PRESCALE_W-1:0] div;
   logic lf_s1;
   logic lf_s2;
   logic lf_s3;
   logic fs_edge;
   logic [2:0] fs_cnt;
   logic [1:0] mc_cnt;
   logic mc_step;

   // low clock arrives from another domain; edges are taken from lf_s2 and lf_s3
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lf_s1 <= 1'b0;
         lf_s2 <= 1'b0;
         lf_s3 <= 1'b0;
      end else begin
         lf_s1 <= lf_clk_pin;
         lf_s2 <= lf_s1;
         lf_s3 <= lf_s2;
      end
   end
   assign fs_edge = lf_s2 && !lf_s3;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div <= '0;
      end else begin
         div <= div + 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fs_cnt <= '0;
      end else if (fs_edge) begin
         fs_cnt <= fs_cnt + 1'b1;
      end
   end

   // machine cycle: fc/4 at full speed, fs/4 at low speed
   assign mc_step = tk.low_speed ? fs_edge : 1'b1;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mc_cnt <= '0;
      end else if (mc_step) begin
         mc_cnt <= mc_cnt + 1'b1;
      end
   end

   // fc taps stay silent at low speed: the fast oscillator may be off
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tk.fc_div2 <= 1'b0;
         tk.fc_div8 <= 1'b0;
         tk.fc_div32 <= 1'b0;
         tk.fc_div128 <= 1'b0;
         tk.fc_div2048 <= 1'b0;
         tk.fs_tick <= 1'b0;
         tk.fs_div8 <= 1'b0;
         tk.mcyc <= 1'b0;
      end else begin
         tk.fc_div2 <= !tk.low_speed && &div[0:0];
         tk.fc_div8 <= !tk.low_speed && &div[2:0];
         tk.fc_div32 <= !tk.low_speed && &div[4:0];
         tk.fc_div128 <= !tk.low_speed && &div[6:0];
         tk.fc_div2048 <= !tk.low_speed && &div[10:0];
         tk.fs_tick <= fs_edge;
         tk.fs_div8 <= fs_edge && fs_cnt == FS_DIV8_LAST;
         tk.mcyc <= mc_step && mc_cnt == MCYC_DIV_LAST;
      end
   end
endmodule

// >>> design/cwt_ext_sampler.sv
// external count pin filter: each level must hold two machine cycles
`timescale 1ns/1ps
module cwt_ext_sampler (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ext_count_pin,
   cwt_tick_if.sampler tk
);
   import cwt_pkg::*;

   logic pin_s1;
   logic pin_s2;
   logic [2:0] hist;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
      end else begin
         pin_s1 <= ext_count_pin;
         pin_s2 <= pin_s1;
      end
   end

   // falling edge counted only after high, high, low, low samples
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hist <= '0;
         tk.ext_tick <= 1'b0;
      end else begin
         tk.ext_tick <= tk.mcyc && {hist, pin_s2} == 4'hC;
         if (tk.mcyc) begin
            hist <= {hist[1:0], pin_s2};
         end
      end
   end
endmodule

// >>> tb/cwt_assertions.sv
// port-level assertion checker for the cascaded timer
`timescale 1ns/1ps
module cwt_assertions (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic upper_timer_interrupt,
   input wire logic pwm_output_pin,
   input wire logic pulse_generator_pin,
   input wire logic timer_output_flipflop
);
   import cwt_pkg::*;
   logic up_dp;
   logic run;
   logic preset_q;
   logic [2:0] mode;
   // mirror of start, mode and preset as written by software
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         up_dp <= 1'b0;
         run <= 1'b0;
         preset_q <= 1'b0;
         mode <= 3'h0;
      end else begin
         up_dp <= hsel && htrans[1] && hready && hwrite &&
            haddr[7:0] == OFF_UPPER_CTRL;
         if (up_dp) begin
            run <= hwdata[CTRL_START_BIT];
            preset_q <= hwdata[CTRL_PRESET_BIT];
            mode <= hwdata[2:0];
         end
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_ready_high: assert property (hreadyout)
      else $error("hreadyout low");
   a_resp_okay: assert property (!hresp)
      else $error("hresp not okay");
   a_ppg_inverse: assert property (
      pulse_generator_pin != timer_output_flipflop)
      else $error("pulse pin not inverse of flip-flop");
   a_pwm_inverse: assert property (
      pwm_output_pin != timer_output_flipflop)
      else $error("pwm pin not inverse of flip-flop");
   a_reset_clear: assert property (
      $rose(hresetn) |-> !timer_output_flipflop && !upper_timer_interrupt)
      else $error("flip-flop or interrupt set after reset");
   a_idle_hold: assert property (
      !run && !$past(run) && !up_dp |=> $stable(timer_output_flipflop))
      else $error("stopped flip-flop changed");
   a_preset_load: assert property (
      up_dp && !run |=> timer_output_flipflop == preset_q)
      else $error("preset not loaded while stopped");
   a_ppg_irq_flip: assert property (
      mode == MODE_PPG && upper_timer_interrupt |->
      timer_output_flipflop != $past(timer_output_flipflop) ||
      $past(timer_output_flipflop) != $past(timer_output_flipflop, 2))
      else $error("period interrupt without flip-flop toggle");
   a_irq_pulse: assert property (
      upper_timer_interrupt |=> !upper_timer_interrupt)
      else $error("interrupt wider than one cycle");
endmodule

// >>> tb/testbench.sv
// self-checking bench for the cascaded timer over ahb-lite
`timescale 1ns/1ps
module testbench;
   import cwt_pkg::*;
   localparam logic [2:0] CODE [9] = '{6, 5, 3, 2, 1, 0, 4, 7, 0};
   localparam int DIV [9] = '{1, 2, 8, 32, 128, 2048, 20, 16, 160};
   logic hclk, hresetn, hsel, hwrite, lf_clk_pin, ext_count_pin;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout, hresp, upper_timer_interrupt;
   logic pwm_output_pin, pulse_generator_pin, timer_output_flipflop;
   int err_total, tests_run, cyc;
   cwt_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .lf_clk_pin, .ext_count_pin, .upper_timer_interrupt,
      .pwm_output_pin, .pulse_generator_pin, .timer_output_flipflop);
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // slow clock of 20 cycles and count pin at the fc/16 limit
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      lf_clk_pin <= (cyc % 20) < 10;
      ext_count_pin <= (cyc % 16) < 8;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // address phase held until hready, then data phase until hready
   task bus(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, a, 8'h00, x);
      chk(x, exp);
   endtask
   task wait_irq(output int n);
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (upper_timer_interrupt !== 1'b1 && n < 20000);
   endtask
   task spacing(input int exp);
      int n;
      wait_irq(n);
      wait_irq(n);
      chk(n, exp);
   endtask
   task wait_ff(input logic lvl, output int n);
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (timer_output_flipflop !== lvl && n < 20000);
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task t_reset;
      chk({28'h0, hreadyout, pulse_generator_pin, pwm_output_pin,
         timer_output_flipflop}, 32'hE);
      for (int i = 0; i < 8; i++) rd_chk(8'(i * 4), 32'h0);
      // unmapped place must swallow writes
      wr(8'h40, 8'hAA);
      rd_chk(8'h40, 32'h0);
      $display("test reset done");
   endtask
   task t_ppg;
      int n;
      wr(OFF_WIDTH_LO, 8'h02);
      wr(OFF_WIDTH_HI, 8'h00);
      wr(OFF_PERIOD_LO, 8'h05);
      wr(OFF_PERIOD_HI, 8'h01);
      wr(OFF_LOWER_CTRL, 8'h63);
      wr(OFF_UPPER_CTRL, 8'h57);
      wr(OFF_UPPER_CTRL, 8'h5F);
      spacing(261);
      wait_ff(1'b1, n);
      wait_ff(1'b0, n);
      chk(n, 259);
      $display("test ppg done");
   endtask
   task t_stop;
      logic f;
      wr(OFF_UPPER_CTRL, 8'h57);
      @(posedge hclk);
      f = timer_output_flipflop;
      repeat (300) @(posedge hclk);
      chk({31'h0, timer_output_flipflop}, {31'h0, f});
      wr(OFF_UPPER_CTRL, 8'hD7);
      @(posedge hclk);
      chk({30'h0, pulse_generator_pin, timer_output_flipflop},
         32'h1);
      wr(OFF_UPPER_CTRL, 8'h57);
      @(posedge hclk);
      chk({31'h0, timer_output_flipflop}, 32'h0);
      $display("test stop done");
   endtask
   task t_clk;
      wr(OFF_WIDTH_LO, 8'h01);
      wr(OFF_WIDTH_HI, 8'h00);
      wr(OFF_PERIOD_LO, 8'h04);
      wr(OFF_PERIOD_HI, 8'h00);
      // last entry reruns the slowest tap with divider select set
      for (int i = 0; i < 9; i++) begin
         wr(OFF_UPPER_CTRL, 8'h57);
         wr(OFF_SYS_CTRL, (i == 8) ? 8'h01 : 8'h00);
         wr(OFF_LOWER_CTRL, {1'b0, CODE[i], 4'h3});
         wr(OFF_UPPER_CTRL, 8'h5F);
         spacing(4 * DIV[i]);
      end
      wr(OFF_UPPER_CTRL, 8'h57);
      wr(OFF_SYS_CTRL, 8'h00);
      $display("test clock select done");
   endtask
   task t_warm;
      wr(OFF_PERIOD_LO, 8'hFF);
      wr(OFF_PERIOD_HI, 8'h02);
      wr(OFF_LOWER_CTRL, 8'h63);
      wr(OFF_UPPER_CTRL, 8'h05);
      wr(OFF_UPPER_CTRL, 8'h0D);
      spacing(512);
      wr(OFF_UPPER_CTRL, 8'h05);
      wr(OFF_PERIOD_HI, 8'h01);
      wr(OFF_UPPER_CTRL, 8'h0D);
      spacing(256);
      // stop and go to low speed as a handler would, then time on fs
      wr(OFF_UPPER_CTRL, 8'h05);
      wr(OFF_SYS_CTRL, 8'h02);
      wr(OFF_LOWER_CTRL, 8'h43);
      wr(OFF_UPPER_CTRL, 8'h0D);
      spacing(256 * 20);
      wr(OFF_UPPER_CTRL, 8'h05);
      wr(OFF_SYS_CTRL, 8'h00);
      $display("test warm-up done");
   endtask
   task t_pwm;
      wr(OFF_WIDTH_LO, 8'h10);
      wr(OFF_WIDTH_HI, 8'h00);
      wr(OFF_LOWER_CTRL, 8'h63);
      wr(OFF_UPPER_CTRL, 8'h56);
      wr(OFF_UPPER_CTRL, 8'h5E);
      repeat (40) @(posedge hclk);
      chk({31'h0, timer_output_flipflop}, 32'h1);
      // a new width must wait for overflow, so no early toggle back
      wr(OFF_WIDTH_LO, 8'h80);
      rd_chk(OFF_WIDTH_LO, 32'h80);
      repeat (200) @(posedge hclk);
      chk({31'h0, timer_output_flipflop}, 32'h1);
      wr(OFF_UPPER_CTRL, 8'h56);
      $display("test pwm done");
   endtask
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      lf_clk_pin = 1'b0;
      ext_count_pin = 1'b0;
      err_total = 0;
      tests_run = 0;
      cyc = 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset;
      t_ppg;
      t_stop;
      t_clk;
      t_warm;
      t_pwm;
      stop_test;
   end
   // run needs about 35k cycles; cut off well past that
   initial begin
      #800_000;
      err_total++;
      $display("watchdog expired");
      stop_test;
   end
endmodule
bind cwt_top cwt_assertions u_chk (.hclk, .hresetn, .hsel, .haddr,
   .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
   .upper_timer_interrupt, .pwm_output_pin, .pulse_generator_pin,
   .timer_output_flipflop);
